// file: hw/simd_consts.svh
// named constants of the safety input monitor display
`ifndef SIMD_CONSTS_SVH
`define SIMD_CONSTS_SVH
`define SIMD_CLK_KHZ      25000
`define SIMD_DEB_MS       10
`define SIMD_HOLD_MS      1000
`define SIMD_SAFETY_MON   12'h015
`define SIMD_PWR_STATUS   16'h0fff
`define SIMD_NUM_RST      12'h000
`define SIMD_NUM_STEP     12'h001
`define SIMD_CNT_ZERO     25'h0000000
`define SIMD_CNT_ONE      25'h0000001
`define SIMD_SEG_TOP      8'h01
`define SIMD_SEG_BOT      8'h08
`define SIMD_SEG_BLANK    8'h00
`define SIMD_KEY_MODE     0
`define SIMD_KEY_UP       1
`define SIMD_KEY_DOWN     2
`define SIMD_KEY_DATA     3
`define SIMD_NKEYS        4
`define SIMD_NPOS         8
`endif

// file: hw/simd_key_filter.sv
// key debounce, press pulses and long-hold detect for the data key
`timescale 1ns/1ns
`include "simd_consts.svh"
module simd_key_filter #(
    parameter int DEB_CYC  = `SIMD_DEB_MS * `SIMD_CLK_KHZ,
    parameter int HOLD_CYC = `SIMD_HOLD_MS * `SIMD_CLK_KHZ
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    // raw keys, high while pressed
    input  wire logic [`SIMD_NKEYS-1:0]   key_raw,
    // filtered events
    simd_key_if.filt                      k
);
    typedef struct packed {
        logic [`SIMD_NKEYS-1:0]                 stable;
        logic [`SIMD_NKEYS-1:0]                 press;
        simd_pkg::simd_cnt_t [`SIMD_NKEYS-1:0]  deb_cnt;
        simd_pkg::simd_cnt_t                    hold_cnt;
        logic                                   long_done;
        logic                                   long_p;
    } simd_filt_s;

    simd_filt_s st_q;
    simd_filt_s st_d;

    ////////////////////////////////////////////////////////////////////////
    // next state: bounces shorter than the debounce time never reach stable
    always_comb begin
        st_d       = st_q;
        st_d.press = '0;
        st_d.long_p = 1'b0;
        for (int i = 0; i < `SIMD_NKEYS; i++) begin
            if (key_raw[i] == st_q.stable[i]) begin
                st_d.deb_cnt[i] = `SIMD_CNT_ZERO;
            end else if (st_q.deb_cnt[i] >= simd_pkg::simd_cnt_t'(DEB_CYC - 1)) begin
                st_d.deb_cnt[i] = `SIMD_CNT_ZERO;
                st_d.stable[i]  = key_raw[i];
                st_d.press[i]   = key_raw[i];
            end else begin
                st_d.deb_cnt[i] = st_q.deb_cnt[i] + `SIMD_CNT_ONE;
            end
        end
        // long hold fires once per press; early release clears the count
        if (!st_q.stable[`SIMD_KEY_DATA]) begin
            st_d.hold_cnt  = `SIMD_CNT_ZERO;
            st_d.long_done = 1'b0;
        end else if (!st_q.long_done) begin
            if (st_q.hold_cnt >= simd_pkg::simd_cnt_t'(HOLD_CYC - 1)) begin
                st_d.long_p    = 1'b1;
                st_d.long_done = 1'b1;
            end else begin
                st_d.hold_cnt = st_q.hold_cnt + `SIMD_CNT_ONE;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // event outputs
    assign k.mode_press = st_q.press[`SIMD_KEY_MODE];
    assign k.up_press   = st_q.press[`SIMD_KEY_UP];
    assign k.down_press = st_q.press[`SIMD_KEY_DOWN];
    assign k.data_long  = st_q.long_p;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    long_after_hold_a: assert property (st_q.long_p |->
        $past(st_q.hold_cnt) == simd_pkg::simd_cnt_t'(HOLD_CYC - 1)
        && $past(st_q.stable[`SIMD_KEY_DATA]))
        else $error("long hold reported before full hold time");
endmodule : simd_key_filter

// file: hw/simd_key_if.sv
// key events passed from the key filter to the display controller
`timescale 1ns/1ns
interface simd_key_if;
    logic mode_press;
    logic up_press;
    logic down_press;
    logic data_long;
    modport filt (output mode_press, output up_press, output down_press, output data_long);
    modport ctrl (input mode_press, input up_press, input down_press, input data_long);
endinterface : simd_key_if

// file: hw/simd_monitor.sv
// safety input monitor display: mode control and 7-segment drive
//
// What this block does
// - In monitor number mode, up and down keys step the monitor number; in data mode they are ignored.
// - Long data key on safety item number shows the live safety inputs.
// - Long data key while inputs are shown returns to the number.
// - Input ON lights only the top segment of its digit.
// - Input OFF lights only the bottom segment of its digit.
// - Position 1 shows input 1, position 2 input 2; 3 to 8 stay dark.
// - Power-up selection below 0fff starts on that monitor item's data.
// - Power-up selection 0fff starts in status display, baseblock or run.
`timescale 1ns/1ns
`include "simd_consts.svh"
module simd_monitor #(
    parameter int DEB_CYC  = `SIMD_DEB_MS * `SIMD_CLK_KHZ,
    parameter int HOLD_CYC = `SIMD_HOLD_MS * `SIMD_CLK_KHZ
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    // operator keys, high while pressed
    input  wire logic                       key_mode,
    input  wire logic                       key_up,
    input  wire logic                       key_down,
    input  wire logic                       key_data,
    // safety inputs, high when terminals short-circuited (ON)
    input  wire logic                       safety_block_input_1,
    input  wire logic                       safety_block_input_2,
    // drive state and power-on selection
    input  wire logic                       run_active,
    input  wire logic [15:0]                power_on_monitor_select,
    // display, position 1 in bits 7:0, segments a..g in bits 0..6, dp bit 7
    output logic [`SIMD_NPOS*8-1:0]         disp_seg,
    output simd_pkg::simd_mode_e            disp_mode,
    output logic [11:0]                     monitor_number
);
    typedef struct packed {
        simd_pkg::simd_mode_e            mode;
        logic [11:0]                     num;
        logic                            init_done;
        logic [`SIMD_NPOS-1:0][7:0]      seg;
    } simd_ctrl_s;

    simd_ctrl_s st_q;
    simd_ctrl_s st_d;
    simd_key_if k ();

    ////////////////////////////////////////////////////////////////////////
    // key filtering
    simd_key_filter #(
        .DEB_CYC  (DEB_CYC),
        .HOLD_CYC (HOLD_CYC)
    ) u_keys (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .key_raw ({key_data, key_down, key_up, key_mode}),
        .k       (k)
    );

    // hex digit to segment pattern
    function automatic logic [7:0] simd_hex_seg(input logic [3:0] h);
        case (h)
            4'h0: simd_hex_seg = 8'h3f;
            4'h1: simd_hex_seg = 8'h06;
            4'h2: simd_hex_seg = 8'h5b;
            4'h3: simd_hex_seg = 8'h4f;
            4'h4: simd_hex_seg = 8'h66;
            4'h5: simd_hex_seg = 8'h6d;
            4'h6: simd_hex_seg = 8'h7d;
            4'h7: simd_hex_seg = 8'h07;
            4'h8: simd_hex_seg = 8'h7f;
            4'h9: simd_hex_seg = 8'h6f;
            4'ha: simd_hex_seg = 8'h77;
            4'hb: simd_hex_seg = 8'h7c;
            4'hc: simd_hex_seg = 8'h39;
            4'hd: simd_hex_seg = 8'h5e;
            4'he: simd_hex_seg = 8'h79;
            default: simd_hex_seg = 8'h71;
        endcase
    endfunction : simd_hex_seg

    // one safety input as a single top or bottom bar
    function automatic logic [7:0] simd_bar(input logic on);
        simd_bar = on ? `SIMD_SEG_TOP : `SIMD_SEG_BOT;
    endfunction : simd_bar

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        if (!st_q.init_done) begin
            // first cycle after reset: apply the power-on selection
            st_d.init_done = 1'b1;
            if (power_on_monitor_select < `SIMD_PWR_STATUS) begin
                st_d.mode = simd_pkg::SIMD_MON_DATA;
                st_d.num  = power_on_monitor_select[11:0];
            end else begin
                st_d.mode = simd_pkg::SIMD_STATUS;
            end
        end else begin
            case (st_q.mode)
                simd_pkg::SIMD_STATUS: begin
                    if (k.mode_press) begin
                        st_d.mode = simd_pkg::SIMD_MON_NUM;
                    end
                end
                simd_pkg::SIMD_MON_NUM: begin
                    if (k.mode_press) begin
                        st_d.mode = simd_pkg::SIMD_STATUS;
                    end else if (k.data_long) begin
                        st_d.mode = simd_pkg::SIMD_MON_DATA;
                    end else if (k.up_press) begin
                        st_d.num = st_q.num + `SIMD_NUM_STEP;
                    end else if (k.down_press) begin
                        st_d.num = st_q.num - `SIMD_NUM_STEP;
                    end
                end
                simd_pkg::SIMD_MON_DATA: begin
                    if (k.mode_press) begin
                        st_d.mode = simd_pkg::SIMD_STATUS;
                    end else if (k.data_long) begin
                        st_d.mode = simd_pkg::SIMD_MON_NUM;
                    end
                end
                default: st_d.mode = simd_pkg::SIMD_STATUS;
            endcase
        end

        // segment image from the current mode; one cycle of latency
        st_d.seg = '0;
        case (st_q.mode)
            simd_pkg::SIMD_MON_NUM: begin
                for (int p = 0; p < 3; p++) begin
                    st_d.seg[p] = simd_hex_seg(st_q.num[p*4 +: 4]);
                end
                st_d.seg[3] = 8'h54;  // n
                st_d.seg[4] = 8'h3e;  // U
            end
            simd_pkg::SIMD_MON_DATA: begin
                // only the safety item is shown here; others stay dark
                if (st_q.num == `SIMD_SAFETY_MON) begin
                    st_d.seg[0] = simd_bar(safety_block_input_1);
                    st_d.seg[1] = simd_bar(safety_block_input_2);
                end
            end
            default: begin
                if (run_active) begin
                    st_d.seg[2] = 8'h50;  // r
                    st_d.seg[1] = 8'h1c;  // u
                    st_d.seg[0] = 8'h54;  // n
                end else begin
                    st_d.seg[1] = 8'h7c;  // b
                    st_d.seg[0] = 8'h7c;  // b
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{mode: simd_pkg::SIMD_STATUS, num: `SIMD_NUM_RST,
                      init_done: 1'b0, seg: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign disp_seg       = st_q.seg;
    assign disp_mode      = st_q.mode;
    assign monitor_number = st_q.num;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    step_up_a: assert property (
        st_q.init_done && st_q.mode == simd_pkg::SIMD_MON_NUM && k.up_press
        && !k.mode_press && !k.data_long |=> st_q.num == $past(st_q.num) + `SIMD_NUM_STEP)
        else $error("up key did not step monitor number");
    step_down_a: assert property (
        st_q.init_done && st_q.mode == simd_pkg::SIMD_MON_NUM && k.down_press
        && !k.up_press && !k.mode_press && !k.data_long
        |=> st_q.num == $past(st_q.num) - `SIMD_NUM_STEP)
        else $error("down key did not step monitor number");
    enter_data_a: assert property (
        st_q.init_done && st_q.mode == simd_pkg::SIMD_MON_NUM && k.data_long
        && !k.mode_press |=> st_q.mode == simd_pkg::SIMD_MON_DATA)
        else $error("long data key did not show signal states");
    leave_data_a: assert property (
        st_q.init_done && st_q.mode == simd_pkg::SIMD_MON_DATA && k.data_long
        && !k.mode_press |=> st_q.mode == simd_pkg::SIMD_MON_NUM ##1 disp_seg[39:32] != '0)
        else $error("long data key did not return to monitor number");
    top_bar_a: assert property (
        st_q.mode == simd_pkg::SIMD_MON_DATA && st_q.num == `SIMD_SAFETY_MON
        && safety_block_input_1 |=> disp_seg[7:0] == `SIMD_SEG_TOP)
        else $error("ON input does not light top segment only");
    bottom_bar_a: assert property (
        st_q.mode == simd_pkg::SIMD_MON_DATA && st_q.num == `SIMD_SAFETY_MON
        && !safety_block_input_2 |=> disp_seg[15:8] == `SIMD_SEG_BOT)
        else $error("OFF input does not light bottom segment only");
    reserved_dark_a: assert property (
        st_q.mode == simd_pkg::SIMD_MON_DATA |=> disp_seg[63:16] == '0)
        else $error("reserved positions not dark");
    power_item_a: assert property (
        !st_q.init_done && power_on_monitor_select < `SIMD_PWR_STATUS
        |=> st_q.mode == simd_pkg::SIMD_MON_DATA
            && st_q.num == $past(power_on_monitor_select[11:0]))
        else $error("power-on selection not applied");
    power_status_a: assert property (
        !st_q.init_done && power_on_monitor_select == `SIMD_PWR_STATUS
        |=> st_q.mode == simd_pkg::SIMD_STATUS)
        else $error("default selection did not start in status mode");
    short_press_a: assert property (
        st_q.init_done && !k.data_long && !k.mode_press |=> st_q.mode == $past(st_q.mode))
        else $error("display mode changed without a key event");

    safety_shown_c: cover property (st_q.mode == simd_pkg::SIMD_MON_DATA
        && st_q.num == `SIMD_SAFETY_MON);
    back_to_num_c: cover property (st_q.mode == simd_pkg::SIMD_MON_DATA
        ##1 st_q.mode == simd_pkg::SIMD_MON_NUM);
    run_status_c: cover property (st_q.mode == simd_pkg::SIMD_STATUS && run_active);
endmodule : simd_monitor

// file: hw/simd_pkg.sv
// types shared by the safety input monitor display
package simd_pkg;
    typedef logic [24:0] simd_cnt_t;
    // gray codes along status -> number -> data
    typedef enum logic [1:0] {
        SIMD_STATUS   = 2'b00,
        SIMD_MON_NUM  = 2'b01,
        SIMD_MON_DATA = 2'b11
    } simd_mode_e;
endpackage : simd_pkg

// file: sim/simd_keypad_model.sv
// keypad model: drives the four raw operator keys, clean or chattering
`timescale 1ns/1ns
module simd_keypad_model (
    // clock
    input  wire logic sys_clk,
    // raw keys, high while pressed
    output logic      key_mode,
    output logic      key_up,
    output logic      key_down,
    output logic      key_data
);
    logic [3:0] key_v;

    // bit order follows the key index constants: mode, up, down, data
    assign {key_data, key_down, key_up, key_mode} = key_v;

    initial begin
        key_v = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // hold one key for hold cycles, then leave it up for gap cycles
    // a long hold models a slow operator, a short one a quick tap
    task automatic press(input int idx, input int hold, input int gap);
        @(negedge sys_clk);
        key_v[idx] = 1'b1;
        repeat (hold) @(negedge sys_clk);
        key_v[idx] = 1'b0;
        repeat (gap) @(negedge sys_clk);
    endtask : press

    // contact chatter: one-cycle pulses, far below the debounce span
    task automatic chatter(input int idx, input int n);
        repeat (n) begin
            @(negedge sys_clk);
            key_v[idx] = 1'b1;
            @(negedge sys_clk);
            key_v[idx] = 1'b0;
        end
    endtask : chatter
endmodule : simd_keypad_model

// file: sim/tb.sv
// self-checking bench for the safety input monitor display
`timescale 1ns/1ns
`include "simd_consts.svh"
module tb;
    // short counts keep the run brief; key hold and gap waits derive from them
    localparam int DEB  = 4;
    localparam int HOLD = 20;
    localparam int GAP  = DEB + 4;
    localparam int LONG = DEB + HOLD + 6;

    typedef struct packed {
        logic [15:0] sel;
        logic        run;
        logic [1:0]  mode;
        logic [11:0] num;
        logic [23:0] seg;
        logic [23:0] msk;
    } simd_tb_row_s;

    logic                 sys_clk;
    logic                 rst_b;
    logic                 key_mode;
    logic                 key_up;
    logic                 key_down;
    logic                 key_data;
    logic                 safe_1;
    logic                 safe_2;
    logic                 run_active;
    logic [15:0]          pwr_sel;
    logic [63:0]          disp_seg;
    simd_pkg::simd_mode_e disp_mode;
    logic [11:0]          monitor_number;
    int                   n_mismatch;
    int                   checked;
    simd_tb_row_s         rows [6];

    ////////////////////////////////////////////////////////////////////////////////
    // clock and instances
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    simd_keypad_model kp_u (.sys_clk(sys_clk), .key_mode(key_mode), .key_up(key_up),
                            .key_down(key_down), .key_data(key_data));

    simd_monitor #(.DEB_CYC(DEB), .HOLD_CYC(HOLD)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .key_mode(key_mode), .key_up(key_up),
        .key_down(key_down), .key_data(key_data), .safety_block_input_1(safe_1),
        .safety_block_input_2(safe_2), .run_active(run_active),
        .power_on_monitor_select(pwr_sel), .disp_seg(disp_seg), .disp_mode(disp_mode),
        .monitor_number(monitor_number));

    ////////////////////////////////////////////////////////////////////////////////
    // compare, report and close
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // reset with a given power-on selection, checking the values held in reset
    task automatic do_reset(input logic [15:0] sel);
        @(negedge sys_clk);
        rst_b = 1'b0;
        pwr_sel = sel;
        repeat (12) @(negedge sys_clk);
        chk(disp_seg, 64'h0);
        chk({50'h0, 2'(disp_mode), monitor_number}, 64'h0);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask : do_reset

    // check mode and number after a key action
    task automatic chk_state(input logic [1:0] mode, input logic [11:0] num);
        chk({50'h0, 2'(disp_mode), monitor_number}, {50'h0, mode, num});
    endtask : chk_state

    // watchdog sized well beyond the expected run of about 760 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: power-on table first, then key and display cases
    initial begin
        n_mismatch = 0;
        checked = 0;
        rst_b = 1'b0;
        safe_1 = 1'b1;
        safe_2 = 1'b0;
        run_active = 1'b0;
        pwr_sel = `SIMD_PWR_STATUS;
        // select, run, mode, number, low three digits, digit mask
        rows[0] = {16'h0fff, 1'b0, 2'b00, 12'h000, 24'h007c7c, 24'h00ffff};
        rows[1] = {16'h0fff, 1'b1, 2'b00, 12'h000, 24'h501c54, 24'hffffff};
        rows[2] = {16'hffff, 1'b0, 2'b00, 12'h000, 24'h007c7c, 24'h00ffff};
        rows[3] = {16'h0015, 1'b0, 2'b11, 12'h015, 24'h000801, 24'hffffff};
        rows[4] = {16'h0000, 1'b0, 2'b11, 12'h000, 24'h000000, 24'hffffff};
        rows[5] = {16'h0ffe, 1'b1, 2'b11, 12'hffe, 24'h000000, 24'hffffff};
        foreach (rows[i]) begin
            run_active = rows[i].run;
            do_reset(rows[i].sel);
            chk(64'(disp_mode), 64'(rows[i].mode));
            if (rows[i].mode != 2'b00) begin
                chk(64'(monitor_number), 64'(rows[i].num));
            end
            chk(64'(disp_seg[23:0] & rows[i].msk), 64'(rows[i].seg));
        end
        // status mode: up is ignored, mode key enters monitor numbers
        run_active = 1'b0;
        do_reset(`SIMD_PWR_STATUS);
        kp_u.press(`SIMD_KEY_UP, DEB + 3, GAP);
        chk_state(2'b00, 12'h000);
        kp_u.press(`SIMD_KEY_MODE, DEB + 3, GAP);
        chk_state(2'b01, 12'h000);
        chk(64'(disp_seg[39:24]), 64'h3e54);
        // down from zero wraps, up steps back, then climb to the safety item
        kp_u.press(`SIMD_KEY_DOWN, DEB + 3, GAP);
        chk_state(2'b01, 12'hfff);
        repeat (22) kp_u.press(`SIMD_KEY_UP, DEB + 3, GAP);
        chk_state(2'b01, `SIMD_SAFETY_MON);
        // long data hold shows live safety inputs
        kp_u.press(`SIMD_KEY_DATA, LONG, GAP);
        chk_state(2'b11, `SIMD_SAFETY_MON);
        for (int c = 0; c < 4; c++) begin
            safe_1 = c[0];
            safe_2 = c[1];
            repeat (2) @(negedge sys_clk);
            chk(disp_seg, {48'h0, c[1] ? 8'h01 : 8'h08, c[0] ? 8'h01 : 8'h08});
        end
        // up ignored while data shown; short tap and chatter change nothing
        kp_u.press(`SIMD_KEY_UP, DEB + 3, GAP);
        chk_state(2'b11, `SIMD_SAFETY_MON);
        kp_u.press(`SIMD_KEY_DATA, DEB + HOLD / 2, GAP);
        chk_state(2'b11, `SIMD_SAFETY_MON);
        kp_u.chatter(`SIMD_KEY_DATA, 30);
        repeat (GAP) @(negedge sys_clk);
        chk_state(2'b11, `SIMD_SAFETY_MON);
        // long hold returns to the number, another shows data again, then mode key back to status
        kp_u.press(`SIMD_KEY_DATA, LONG, GAP);
        chk_state(2'b01, `SIMD_SAFETY_MON);
        kp_u.press(`SIMD_KEY_DATA, LONG, GAP);
        chk_state(2'b11, `SIMD_SAFETY_MON);
        kp_u.press(`SIMD_KEY_MODE, DEB + 3, GAP);
        chk(64'(disp_mode), 64'h0);
        finish_test();
    end
endmodule : tb
